// *** logic/elsic_pkg.sv ***
package elsic_pkg;
    // byte-wide parallel port
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    // register offsets
    localparam logic [7:0]  OFF_STATUS_ONE  = 8'h06;
    localparam logic [7:0]  OFF_STATUS_TWO  = 8'h07;
    localparam logic [7:0]  OFF_RX_INFO     = 8'h08;
    localparam logic [7:0]  OFF_IRQ_MASK1   = 8'h16;
    localparam logic [7:0]  OFF_IRQ_MASK2   = 8'h17;
    localparam logic [7:0]  OFF_SYNC_STATUS = 8'h1e;
    localparam logic [7:0]  OFF_TX_MON      = 8'h40;
    localparam logic [7:0]  OFF_RX_MON      = 8'h41;
    localparam logic [7:0]  OFF_LOOP_TXMON  = 8'ha8;
    localparam logic [7:0]  OFF_LINE_INTERFACE_RESET_RXMON = 8'haa;
    // loop_txmon_control_reg fields
    localparam int          BIT_REMOTE_LOOP = 7;
    localparam int          BIT_LOCAL_LOOP  = 6;
    localparam int          BIT_LINE_AIS    = 5;
    // lireset_rxmon_control_reg fields
    localparam int          BIT_LINE_RESET  = 7;
    localparam int          SEL_MSB         = 4;
    localparam int          SEL_LSB         = 0;
    // reset values
    localparam logic [7:0]  RST_BYTE        = 8'h00;
    localparam logic [4:0]  RST_SEL         = 5'h00;
    // status register one: level alarms and change-interrupt alarms
    localparam logic [7:0]  SR1_LEVEL_BITS  = 8'hef;
    localparam logic [7:0]  SR1_CHANGE_BITS = 8'h0f;
    localparam logic [7:0]  EVENT_ONLY_BITS = 8'h00;
    // unused read data
    localparam logic [7:0]  UNMAPPED_DATA   = 8'h00;
endpackage : elsic_pkg

// *** logic/elsic_latch.sv ***
`timescale 1ns/1ps
module elsic_latch #(
    parameter int          WIDTH       = 8,
    parameter logic [7:0]  LEVEL_BITS  = 8'h00,
    parameter logic [7:0]  CHANGE_BITS = 8'h00
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_event,
    input  wire logic [WIDTH-1:0] i_alarm,
    input  wire logic             i_wr,
    input  wire logic             i_rd,
    input  wire logic [WIDTH-1:0] i_wdata,
    input  wire logic [WIDTH-1:0] i_mask,
    output logic      [WIDTH-1:0] o_view,
    output logic                  o_irq
);
    import elsic_pkg::*;

    logic [WIDTH-1:0] latched;
    logic [WIDTH-1:0] armed;
    logic [WIDTH-1:0] alarm_prev;
    logic [WIDTH-1:0] change_pend;
    logic [WIDTH-1:0] lvl;
    logic [WIDTH-1:0] chg;
    logic [WIDTH-1:0] set_src;
    logic [WIDTH-1:0] rd_clr;

    if (WIDTH < 1 || WIDTH > DATA_W) begin : g_bad_width
        $error("elsic_latch: WIDTH out of range");
    end

    // sources: events pulse, level alarms hold the bit set while present
    always_comb begin
        lvl     = LEVEL_BITS[WIDTH-1:0];
        chg     = CHANGE_BITS[WIDTH-1:0];
        set_src = i_event | (i_alarm & lvl);
        rd_clr  = i_rd ? (armed & o_view) : '0;
    end

    // latched bits: set wins over clear-on-read
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            latched <= '0;
        end else begin
            latched <= (latched & ~rd_clr) | set_src;
        end
    end

    // readable copy refreshed only where the write mask holds ones
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_view <= '0;
            armed  <= '0;
        end else if (i_wr) begin
            o_view <= (i_wdata & latched) | (~i_wdata & o_view);
            armed  <= i_wdata;
        end else if (i_rd) begin
            armed  <= '0;
        end
    end

    // alarm change tracking for the change-type interrupt sources
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            alarm_prev  <= '0;
            change_pend <= '0;
        end else begin
            alarm_prev  <= i_alarm;
            change_pend <= (change_pend & ~rd_clr)
                           | ((i_alarm ^ alarm_prev) & chg);
        end
    end

    // combined request of unmasked sources
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(((latched & ~chg) | change_pend) & i_mask);
        end
    end
endmodule : elsic_latch

// *** logic/elsic_ctl.sv ***
// Operation
// - remote loopback returns received line data outward
// - receive framer still fed during remote loopback
// - local loopback replaces received data with transmit
// - locally looped data goes through jitter attenuator
// - line all-ones force sends unframed ones
// - five-bit select picks transmit monitored channel
// - five-bit select picks receive monitored channel
// - rising line reset bit resets recovery, attenuator
// - status bits latch until read then clear
// - level alarms stay set while still present
// - write ones refresh readable status copy
// - sync status is live, read-only, unlatched
// - status one, two drive maskable low interrupt
// - four alarms interrupt on every change
// - alarm interrupt released after bit read
// - event interrupt released after bit read
`timescale 1ns/1ps
module elsic_ctl #(
    parameter int SEL_W = 5
) (
    input  wire logic                      i_clk_sys,
    input  wire logic                      i_rst,
    // parallel control port
    input  wire logic [elsic_pkg::ADDR_W-1:0] i_addr,
    input  wire logic                      i_wr,
    input  wire logic                      i_rd,
    input  wire logic [elsic_pkg::DATA_W-1:0] i_wdata,
    output logic      [elsic_pkg::DATA_W-1:0] o_rdata,
    output logic                           o_int_n,
    // line side
    input  wire logic                      i_line_bit_strobe,
    input  wire logic                      i_rx_line_pos_in,
    input  wire logic                      i_rx_line_neg_in,
    input  wire logic                      i_tx_fmt_pos_in,
    input  wire logic                      i_tx_fmt_neg_in,
    output logic                           o_tx_line_pos_out,
    output logic                           o_tx_line_neg_out,
    output logic                           o_rx_path_pos,
    output logic                           o_rx_path_neg,
    output logic                           o_line_if_reset,
    // channel monitor taps
    input  wire logic [SEL_W-1:0]          i_tx_chan_idx,
    input  wire logic [elsic_pkg::DATA_W-1:0] i_tx_chan_data,
    input  wire logic                      i_tx_chan_valid,
    input  wire logic [SEL_W-1:0]          i_rx_chan_idx,
    input  wire logic [elsic_pkg::DATA_W-1:0] i_rx_chan_data,
    input  wire logic                      i_rx_chan_valid,
    // status sources
    input  wire logic [elsic_pkg::DATA_W-1:0] i_sr1_event,
    input  wire logic [elsic_pkg::DATA_W-1:0] i_sr1_alarm,
    input  wire logic [elsic_pkg::DATA_W-1:0] i_sr2_event,
    input  wire logic [elsic_pkg::DATA_W-1:0] i_rir_event,
    input  wire logic [elsic_pkg::DATA_W-1:0] i_sync_status
);
    import elsic_pkg::*;

    // elaboration check on the select width
    if (SEL_W != SEL_MSB - SEL_LSB + 1) begin : g_bad_sel
        $error("elsic_ctl: SEL_W must match select field");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control registers

    logic [DATA_W-1:0] loop_txmon_control_reg;
    logic [DATA_W-1:0] lireset_rxmon_control_reg;
    logic [DATA_W-1:0] irq_mask_one;
    logic [DATA_W-1:0] irq_mask_two;
    logic [DATA_W-1:0] tx_channel_monitor_reg;
    logic [DATA_W-1:0] rx_channel_monitor_reg;
    logic              line_reset_prev;

    // decode of a write to a given offset
    function automatic logic wr_hit(input logic we, input logic [7:0] a, input logic [7:0] off);
        wr_hit = we && (a == off);
    endfunction : wr_hit

    // host writes to control and mask registers
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            loop_txmon_control_reg    <= RST_BYTE;
            lireset_rxmon_control_reg <= RST_BYTE;
            irq_mask_one              <= RST_BYTE;
            irq_mask_two              <= RST_BYTE;
        end else begin
            if (wr_hit(i_wr, i_addr, OFF_LOOP_TXMON)) begin
                loop_txmon_control_reg <= i_wdata;
            end
            if (wr_hit(i_wr, i_addr, OFF_LINE_INTERFACE_RESET_RXMON)) begin
                lireset_rxmon_control_reg <= i_wdata;
            end
            if (wr_hit(i_wr, i_addr, OFF_IRQ_MASK1)) begin
                irq_mask_one <= i_wdata;
            end
            if (wr_hit(i_wr, i_addr, OFF_IRQ_MASK2)) begin
                irq_mask_two <= i_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // line interface reset trigger

    // one-cycle pulse on a 0-to-1 step of the reset bit
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            line_reset_prev <= 1'b0;
            o_line_if_reset <= 1'b0;
        end else begin
            line_reset_prev <= lireset_rxmon_control_reg[BIT_LINE_RESET];
            o_line_if_reset <= lireset_rxmon_control_reg[BIT_LINE_RESET]
                               & ~line_reset_prev;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // line datapath

    logic remote_loopback_en;
    logic local_loopback_en;
    logic line_all_ones_force;
    logic ais_phase;

    // loop and all-ones controls sampled only at line bit boundaries
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            remote_loopback_en  <= 1'b0;
            local_loopback_en   <= 1'b0;
            line_all_ones_force <= 1'b0;
        end else if (i_line_bit_strobe) begin
            remote_loopback_en  <= loop_txmon_control_reg[BIT_REMOTE_LOOP];
            local_loopback_en   <= loop_txmon_control_reg[BIT_LOCAL_LOOP];
            line_all_ones_force <= loop_txmon_control_reg[BIT_LINE_AIS];
        end
    end

    // transmit line outputs: all-ones marks alternate polarity
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_tx_line_pos_out <= 1'b0;
            o_tx_line_neg_out <= 1'b0;
            ais_phase         <= 1'b0;
        end else if (i_line_bit_strobe) begin
            if (line_all_ones_force) begin
                o_tx_line_pos_out <= ~ais_phase;
                o_tx_line_neg_out <= ais_phase;
                ais_phase         <= ~ais_phase;
            end else if (remote_loopback_en) begin
                o_tx_line_pos_out <= i_rx_line_pos_in;
                o_tx_line_neg_out <= i_rx_line_neg_in;
            end else begin
                o_tx_line_pos_out <= i_tx_fmt_pos_in;
                o_tx_line_neg_out <= i_tx_fmt_neg_in;
            end
        end
    end

    // receive path into the jitter attenuator and framer
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_rx_path_pos <= 1'b0;
            o_rx_path_neg <= 1'b0;
        end else if (i_line_bit_strobe) begin
            if (local_loopback_en) begin
                o_rx_path_pos <= i_tx_fmt_pos_in;
                o_rx_path_neg <= i_tx_fmt_neg_in;
            end else begin
                o_rx_path_pos <= i_rx_line_pos_in;
                o_rx_path_neg <= i_rx_line_neg_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // channel monitors

    // copy the selected channel's byte into each monitor register
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            tx_channel_monitor_reg <= RST_BYTE;
            rx_channel_monitor_reg <= RST_BYTE;
        end else begin
            if (i_tx_chan_valid
                && i_tx_chan_idx == loop_txmon_control_reg[SEL_MSB:SEL_LSB]) begin
                tx_channel_monitor_reg <= i_tx_chan_data;
            end
            if (i_rx_chan_valid
                && i_rx_chan_idx == lireset_rxmon_control_reg[SEL_MSB:SEL_LSB]) begin
                rx_channel_monitor_reg <= i_rx_chan_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // latched status registers

    logic [DATA_W-1:0] status_reg_one;
    logic [DATA_W-1:0] status_reg_two;
    logic [DATA_W-1:0] rx_information_reg;
    logic              irq_one;
    logic              irq_two;
    logic              rd_one;
    logic              rd_two;
    logic              rd_info;

    // read strobes per latched register
    always_comb begin
        rd_one  = i_rd && (i_addr == OFF_STATUS_ONE);
        rd_two  = i_rd && (i_addr == OFF_STATUS_TWO);
        rd_info = i_rd && (i_addr == OFF_RX_INFO);
    end

    elsic_latch #(
        .WIDTH       (DATA_W),
        .LEVEL_BITS  (SR1_LEVEL_BITS),
        .CHANGE_BITS (SR1_CHANGE_BITS)
    ) u_status_one (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_event   (i_sr1_event),
        .i_alarm   (i_sr1_alarm),
        .i_wr      (wr_hit(i_wr, i_addr, OFF_STATUS_ONE)),
        .i_rd      (rd_one),
        .i_wdata   (i_wdata),
        .i_mask    (irq_mask_one),
        .o_view    (status_reg_one),
        .o_irq     (irq_one)
    );

    elsic_latch #(
        .WIDTH       (DATA_W),
        .LEVEL_BITS  (EVENT_ONLY_BITS),
        .CHANGE_BITS (EVENT_ONLY_BITS)
    ) u_status_two (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_event   (i_sr2_event),
        .i_alarm   (RST_BYTE),
        .i_wr      (wr_hit(i_wr, i_addr, OFF_STATUS_TWO)),
        .i_rd      (rd_two),
        .i_wdata   (i_wdata),
        .i_mask    (irq_mask_two),
        .o_view    (status_reg_two),
        .o_irq     (irq_two)
    );

    elsic_latch #(
        .WIDTH       (DATA_W),
        .LEVEL_BITS  (EVENT_ONLY_BITS),
        .CHANGE_BITS (EVENT_ONLY_BITS)
    ) u_rx_info (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_event   (i_rir_event),
        .i_alarm   (RST_BYTE),
        .i_wr      (wr_hit(i_wr, i_addr, OFF_RX_INFO)),
        .i_rd      (rd_info),
        .i_wdata   (i_wdata),
        .i_mask    (RST_BYTE),
        .o_view    (rx_information_reg),
        .o_irq     ()
    );

    // active-low interrupt from both status registers
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_int_n <= 1'b1;
        end else begin
            o_int_n <= ~(irq_one | irq_two);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data

    // registered read mux; sync status is passed live
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= UNMAPPED_DATA;
        end else if (i_rd) begin
            case (i_addr)
                OFF_STATUS_ONE:  o_rdata <= status_reg_one;
                OFF_STATUS_TWO:  o_rdata <= status_reg_two;
                OFF_RX_INFO:     o_rdata <= rx_information_reg;
                OFF_SYNC_STATUS: o_rdata <= i_sync_status;
                OFF_IRQ_MASK1:   o_rdata <= irq_mask_one;
                OFF_IRQ_MASK2:   o_rdata <= irq_mask_two;
                OFF_TX_MON:      o_rdata <= tx_channel_monitor_reg;
                OFF_RX_MON:      o_rdata <= rx_channel_monitor_reg;
                OFF_LOOP_TXMON:  o_rdata <= loop_txmon_control_reg;
                OFF_LINE_INTERFACE_RESET_RXMON: o_rdata <= lireset_rxmon_control_reg;
                default:         o_rdata <= UNMAPPED_DATA;
            endcase
        end
    end
endmodule : elsic_ctl

// *** verification/elsic_checker.sv ***
`timescale 1ns/1ps
module elsic_checker
    import elsic_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_addr,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [7:0] i_wdata,
    input  wire logic [7:0] o_rdata,
    input  wire logic       i_line_bit_strobe,
    input  wire logic       i_rx_line_pos_in,
    input  wire logic       i_rx_line_neg_in,
    input  wire logic       i_tx_fmt_pos_in,
    input  wire logic       i_tx_fmt_neg_in,
    input  wire logic       o_tx_line_pos_out,
    input  wire logic       o_tx_line_neg_out,
    input  wire logic       o_rx_path_pos,
    input  wire logic       o_rx_path_neg,
    input  wire logic       o_line_if_reset,
    input  wire logic [7:0] i_sync_status
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    logic [7:0] ctl_q;
    logic [7:0] snap;
    logic       lir_q;
    wire        cause = i_wr && i_addr == OFF_LINE_INTERFACE_RESET_RXMON && i_wdata[7] && !lir_q;
    wire        unmapped = !(i_addr inside {OFF_STATUS_ONE, OFF_STATUS_TWO, OFF_RX_INFO,
        OFF_IRQ_MASK1, OFF_IRQ_MASK2, OFF_SYNC_STATUS, OFF_TX_MON, OFF_RX_MON,
        OFF_LOOP_TXMON, OFF_LINE_INTERFACE_RESET_RXMON});
    ////////////////////////////////////////////////////////////////////////////////
    // shadow of the line control byte and its snapshot at each bit boundary
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ctl_q <= 8'h00;
            snap  <= 8'h00;
        end else begin
            if (i_wr && i_addr == OFF_LOOP_TXMON) ctl_q <= i_wdata;
            if (i_line_bit_strobe) snap <= ctl_q;
        end
    end
    // last written line reset bit
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) lir_q <= 1'b0;
        else if (i_wr && i_addr == OFF_LINE_INTERFACE_RESET_RXMON) lir_q <= i_wdata[7];
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_reset_pulse;
        ##2 o_line_if_reset ##1 !o_line_if_reset;
    endsequence
    a_line_hold: assert property (!i_line_bit_strobe |=> $stable({o_tx_line_pos_out,
        o_tx_line_neg_out, o_rx_path_pos, o_rx_path_neg})) else $error("line moved off boundary");
    a_remote_loop: assert property (i_line_bit_strobe && snap[7] && !snap[5] |=>
        o_tx_line_pos_out == $past(i_rx_line_pos_in) &&
        o_tx_line_neg_out == $past(i_rx_line_neg_in)) else $error("remote loop data wrong");
    a_rx_normal: assert property (i_line_bit_strobe && !snap[6] |=>
        o_rx_path_pos == $past(i_rx_line_pos_in) && o_rx_path_neg == $past(i_rx_line_neg_in))
        else $error("receive path wrong");
    a_local_loop: assert property (i_line_bit_strobe && snap[6] |=>
        o_rx_path_pos == $past(i_tx_fmt_pos_in) && o_rx_path_neg == $past(i_tx_fmt_neg_in))
        else $error("local loop data wrong");
    a_tx_normal: assert property (i_line_bit_strobe && !snap[7] && !snap[5] |=>
        o_tx_line_pos_out == $past(i_tx_fmt_pos_in) && o_tx_line_neg_out == $past(i_tx_fmt_neg_in))
        else $error("transmit data wrong");
    a_all_ones: assert property (i_line_bit_strobe && snap[5] |=>
        o_tx_line_pos_out != o_tx_line_neg_out) else $error("all ones not sent");
    a_reset_pulse: assert property (cause |-> s_reset_pulse) else $error("no line reset");
    a_reset_cause: assert property ($rose(o_line_if_reset) |-> $past(cause, 2))
        else $error("stray line reset");
    a_sync_live: assert property (i_rd && i_addr == OFF_SYNC_STATUS |=>
        o_rdata == $past(i_sync_status)) else $error("sync status not live");
    a_unmapped_zero: assert property (i_rd && unmapped |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!i_rd |=> $stable(o_rdata)) else $error("read data moved");
endmodule : elsic_checker

// *** verification/elsic_host.sv ***
`timescale 1ns/1ps
module elsic_host (
    input  wire logic       i_clk_sys,
    input  wire logic [7:0] i_rdata,
    output logic      [7:0] o_addr,
    output logic            o_wr,
    output logic            o_rd,
    output logic      [7:0] o_wdata
);
    // idle bus at time zero
    initial begin
        o_addr = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 8'h00;
    end
    // one-cycle write strobe; unassigned bits 6:5 go out as zero on line reset register writes only
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        o_addr = a;
        o_wdata = (a == elsic_pkg::OFF_LINE_INTERFACE_RESET_RXMON) ? (d & 8'h9f) : d;
        o_wr = 1'b1;
        @(negedge i_clk_sys);
        o_wr = 1'b0;
    endtask : wr_reg
    // one-cycle read strobe, data taken a cycle later
    task rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk_sys);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_clk_sys);
        o_rd = 1'b0;
        @(negedge i_clk_sys);
        d = i_rdata;
    endtask : rd_reg
    // mask write, read, then write back the masked result to clear
    task poll(input logic [7:0] a, input logic [7:0] m, output logic [7:0] d);
        wr_reg(a, m);
        rd_reg(a, d);
        wr_reg(a, d & m);
    endtask : poll
endmodule : elsic_host

// *** verification/elsic_ctl_tb.sv ***
`timescale 1ns/1ps
module elsic_ctl_tb;
    import elsic_pkg::*;
    logic       i_clk_sys = 1'b0;
    logic       i_rst = 1'b1;
    logic [7:0] i_addr, i_wdata, o_rdata, d;
    logic       i_wr, i_rd, o_int_n, o_lp, o_ln, o_rp, o_rn, o_lir;
    logic       strb = 1'b0, rp = 1'b0, rn = 1'b0, fp = 1'b0, fn = 1'b0;
    logic [4:0] tidx = 5'h00, ridx = 5'h00;
    logic [7:0] tdat = 8'h00, rdat = 8'h00, e1 = 8'h00, a1 = 8'h00, e2 = 8'h00;
    logic [7:0] er = 8'h00, sy = 8'h00;
    logic       tval = 1'b0, rval = 1'b0;
    int         n_fail = 0, comparisons = 0, n_lir = 0, i;
    logic [7:0] r_ctl [6] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'h40, 8'h40};
    logic [3:0] r_in  [6] = '{4'h9, 4'h6, 4'h9, 4'h6, 4'h9, 4'h6};
    logic [3:0] r_exp [6] = '{4'h9, 4'h6, 4'h5, 4'ha, 4'ha, 4'h5};
    always #2 i_clk_sys = ~i_clk_sys;
    // count line interface reset pulses
    always @(negedge i_clk_sys) if (o_lir === 1'b1) n_lir++;
    elsic_host u_elsic_host (.i_clk_sys(i_clk_sys), .i_rdata(o_rdata), .o_addr(i_addr),
        .o_wr(i_wr), .o_rd(i_rd), .o_wdata(i_wdata));
    elsic_ctl u_elsic_ctl (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr),
        .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_int_n(o_int_n),
        .i_line_bit_strobe(strb), .i_rx_line_pos_in(rp), .i_rx_line_neg_in(rn),
        .i_tx_fmt_pos_in(fp), .i_tx_fmt_neg_in(fn), .o_tx_line_pos_out(o_lp),
        .o_tx_line_neg_out(o_ln), .o_rx_path_pos(o_rp), .o_rx_path_neg(o_rn),
        .o_line_if_reset(o_lir), .i_tx_chan_idx(tidx), .i_tx_chan_data(tdat),
        .i_tx_chan_valid(tval), .i_rx_chan_idx(ridx), .i_rx_chan_data(rdat),
        .i_rx_chan_valid(rval), .i_sr1_event(e1), .i_sr1_alarm(a1), .i_sr2_event(e2),
        .i_rir_event(er), .i_sync_status(sy));
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // one line bit: dual-rail inputs {fmt pos, fmt neg, rx pos, rx neg}
    task bit_out(input logic [3:0] v);
        @(negedge i_clk_sys);
        {fp, fn, rp, rn} = v;
        strb = 1'b1;
        @(negedge i_clk_sys);
        strb = 1'b0;
    endtask : bit_out
    // bounded wait for the interrupt level
    task wait_int(input logic lvl);
        for (int k = 0; k < 12 && o_int_n !== lvl; k++) @(negedge i_clk_sys);
        chk({7'h00, o_int_n}, {7'h00, lvl});
    endtask : wait_int
    // one-cycle event pulse on status one, two or the information byte
    task ev(input int w, input logic [7:0] v);
        @(negedge i_clk_sys);
        if (w == 0) e1 = v;
        else if (w == 1) e2 = v;
        else er = v;
        @(negedge i_clk_sys);
        {e1, e2, er} = 24'h000000;
    endtask : ev
    task results;
        if (n_fail == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        n_fail++;
        results();
    end
    initial begin
        repeat (5) @(negedge i_clk_sys);
        i_rst = 1'b0;
        chk({7'h00, o_int_n}, 8'h01);
        u_elsic_host.rd_reg(OFF_LOOP_TXMON, d);
        chk(d, RST_BYTE);
        // line modes, applied from the second boundary after the write
        for (i = 0; i < 6; i++) begin
            u_elsic_host.wr_reg(OFF_LOOP_TXMON, r_ctl[i]);
            bit_out(4'h0);
            bit_out(4'h0);
            bit_out(r_in[i]);
            chk({4'h0, o_lp, o_ln, o_rp, o_rn}, {4'h0, r_exp[i]});
        end
        // all ones wins over remote loop and alternates
        u_elsic_host.wr_reg(OFF_LOOP_TXMON, 8'ha0);
        bit_out(4'h0);
        bit_out(4'h0);
        bit_out(4'h0);
        chk({6'h00, o_lp, o_ln}, 8'h01);
        bit_out(4'h0);
        chk({6'h00, o_lp, o_ln}, 8'h02);
        // channel monitors at transmit select 0x13 and the top receive select 0x1f
        u_elsic_host.wr_reg(OFF_LOOP_TXMON, 8'h13);
        u_elsic_host.wr_reg(OFF_LINE_INTERFACE_RESET_RXMON, 8'h1f);
        @(negedge i_clk_sys);
        {tidx, tdat, tval, ridx, rdat, rval} = {5'h13, 8'ha5, 1'b1, 5'h1f, 8'h3c, 1'b1};
        @(negedge i_clk_sys);
        {tidx, tdat, ridx, rdat} = {5'h12, 8'h5a, 5'h1e, 8'hc3};
        @(negedge i_clk_sys);
        {tval, rval} = 2'b00;
        u_elsic_host.rd_reg(OFF_TX_MON, d);
        chk(d, 8'ha5);
        u_elsic_host.rd_reg(OFF_RX_MON, d);
        chk(d, 8'h3c);
        // unmapped access: zero on read, write ignored
        u_elsic_host.wr_reg(8'h55, 8'hff);
        u_elsic_host.rd_reg(8'h55, d);
        chk(d, 8'h00);
        u_elsic_host.rd_reg(OFF_LOOP_TXMON, d);
        chk(d, 8'h13);
        // line reset fires on a rising bit only
        u_elsic_host.wr_reg(OFF_LINE_INTERFACE_RESET_RXMON, 8'hff);
        u_elsic_host.wr_reg(OFF_LINE_INTERFACE_RESET_RXMON, 8'h9f);
        u_elsic_host.wr_reg(OFF_LINE_INTERFACE_RESET_RXMON, 8'h1f);
        u_elsic_host.wr_reg(OFF_LINE_INTERFACE_RESET_RXMON, 8'h9f);
        repeat (4) @(negedge i_clk_sys);
        chk(n_lir[7:0], 8'h02);
        u_elsic_host.rd_reg(OFF_LINE_INTERFACE_RESET_RXMON, d);
        chk(d, 8'h9f);
        // live synchronizer status
        sy = 8'h9c;
        u_elsic_host.rd_reg(OFF_SYNC_STATUS, d);
        chk(d, 8'h9c);
        sy = 8'h31;
        u_elsic_host.rd_reg(OFF_SYNC_STATUS, d);
        chk(d, 8'h31);
        // masked event, stale copy, then unmask and clear
        ev(0, 8'h10);
        repeat (8) @(negedge i_clk_sys);
        chk({7'h00, o_int_n}, 8'h01);
        u_elsic_host.rd_reg(OFF_STATUS_ONE, d);
        chk(d, 8'h00);
        u_elsic_host.wr_reg(OFF_IRQ_MASK1, 8'h10);
        wait_int(1'b0);
        u_elsic_host.poll(OFF_STATUS_ONE, 8'h10, d);
        chk(d, 8'h10);
        wait_int(1'b1);
        u_elsic_host.poll(OFF_STATUS_ONE, 8'h10, d);
        chk(d, 8'h00);
        // level alarm held while present
        a1 = 8'h80;
        for (i = 0; i < 3; i++) begin
            u_elsic_host.poll(OFF_STATUS_ONE, 8'h80, d);
            chk(d, 8'h80);
            if (i == 1) a1 = 8'h00;
        end
        u_elsic_host.poll(OFF_STATUS_ONE, 8'h80, d);
        chk(d, 8'h00);
        // change alarm: interrupt on both edges, released by the read
        u_elsic_host.wr_reg(OFF_IRQ_MASK1, 8'h01);
        for (i = 0; i < 2; i++) begin
            a1 = (i == 0) ? 8'h01 : 8'h00;
            wait_int(1'b0);
            u_elsic_host.poll(OFF_STATUS_ONE, 8'h01, d);
            chk(d, 8'h01);
            wait_int(1'b1);
        end
        // status two through its own mask; information byte never interrupts
        u_elsic_host.wr_reg(OFF_IRQ_MASK2, 8'h01);
        ev(1, 8'h01);
        wait_int(1'b0);
        u_elsic_host.poll(OFF_STATUS_TWO, 8'h01, d);
        chk(d, 8'h01);
        wait_int(1'b1);
        ev(2, 8'h20);
        u_elsic_host.poll(OFF_RX_INFO, 8'h20, d);
        chk(d, 8'h20);
        chk({7'h00, o_int_n}, 8'h01);
        results();
    end
endmodule : elsic_ctl_tb
bind elsic_ctl elsic_checker u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
    .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .i_line_bit_strobe(i_line_bit_strobe), .i_rx_line_pos_in(i_rx_line_pos_in),
    .i_rx_line_neg_in(i_rx_line_neg_in), .i_tx_fmt_pos_in(i_tx_fmt_pos_in),
    .i_tx_fmt_neg_in(i_tx_fmt_neg_in), .o_tx_line_pos_out(o_tx_line_pos_out),
    .o_tx_line_neg_out(o_tx_line_neg_out), .o_rx_path_pos(o_rx_path_pos),
    .o_rx_path_neg(o_rx_path_neg), .o_line_if_reset(o_line_if_reset),
    .i_sync_status(i_sync_status));
